// File: cprs_core.sv
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - One 8-bit accumulator holds operands and receives ALU results.
// - 16-bit index register, upper and lower bytes, used as one pointer.
// - Indexed modes form effective address from index register.
// - Reset loads stack pointer with 00FF.
// - Reset-stack-low instruction sets low byte to FF, keeps high byte.
// - Push decrements stack pointer, pull increments it.
// - Stack-offset modes use stack pointer as address base.
// - Program counter steps per fetch; jumps and interrupts load new address.
// - Reset loads program counter from vector at FFFE and FFFF.
// - Flag bits 6 and 5 always read one; writes ignored.
// - Overflow flag reflects two's complement overflow.
// - Half-carry set on carry from bit 3 into bit 4 in adds.
// - Decimal adjust picks correction from half-carry and carry.
// - Mask blocks maskable interrupts; set after stacking, before vector fetch.
// - After mask clears, highest-priority pending request is served first.
// - Interrupt entry does not stack the index upper byte.
// - Interrupt return restores stacked registers including the mask.
// - Every reset sets mask; only mask-clear instruction clears it otherwise; interrupt return and APB flag writes also clear it here.
// - Negative flag follows result bit 7.
// - Zero flag set when result is zero.
// - Carry flag from add carry-out, subtract borrow, shifts.
`include "cprs_regs.svh"
module cprs_core
  import cprs_pkg::*;
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        CLK_EN_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Execution interface
  input  wire cprs_op_e    OP_IN,
  input  wire logic [7:0]  OPERAND_IN,
  input  wire logic [15:0] PULL_DATA_IN,
  input  wire logic        FETCH_IN,
  input  wire logic [15:0] JUMP_ADDR_IN,
  input  wire logic        VECTOR_LOAD_IN,
  input  wire logic [15:0] VECTOR_IN,
  input  wire cprs_am_e    ADDR_MODE_IN,
  input  wire logic [15:0] OFFSET_IN,
  output logic      [15:0] EFF_ADDR_OUT,
  output logic      [15:0] PROG_ADDR_OUT,
  output logic      [15:0] STACK_ADDR_OUT,
  output logic      [7:0]  ACC_OUT,
  output logic      [7:0]  FLAGS_OUT,
  // Interrupt entry and reset vector request handshake
  output logic             INT_TAKE_OUT,
  output logic      [2:0]  INT_NUM_OUT,
  output logic             RESET_VEC_REQ_OUT
);

  logic [7:0]  acc_q, acc_d;
  logic [15:0] index_q, index_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  flags_q, flags_d;
  logic [7:0]  int_req_q, int_req_d;
  logic        int_take_q, int_take_d;
  logic [2:0]  int_num_q, int_num_d;
  logic        vec_pend_q, vec_pend_d;
  logic [15:0] ea_q, ea_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  typedef enum logic [1:0] {CPRS_ST_RUN, CPRS_ST_STACKED, CPRS_ST_VECTOR} cprs_st_e;
  cprs_st_e st_q, st_d;

  // Fold fixed bits into any flag value
  function automatic logic [7:0] cprs_fix(input logic [7:0] f);
    cprs_fix = f | `CPRS_FLAGS_FIX;
  endfunction

  // Lowest-numbered pending request has the highest priority
  function automatic logic [2:0] cprs_prio(input logic [7:0] r);
    cprs_prio = 3'd0;
    for (int k = 7; k >= 0; k--) begin
      if (r[k]) begin
        cprs_prio = 3'(k);
      end
    end
  endfunction

  logic        apb_acc;
  logic [3:0]  idx;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [7:0]  res, corr;
  logic        cin;
  logic        upd_nz;

  assign apb_acc = PSEL_IN & PENABLE_IN & ~pready_q;
  assign idx     = PADDR_IN[5:2];

  // Register set, ALU flags, interrupt sequencing and APB
  always_comb begin
    acc_d      = acc_q;
    index_d    = index_q;
    sp_d       = sp_q;
    pc_d       = pc_q;
    flags_d    = flags_q;
    int_req_d  = int_req_q;
    int_take_d = 1'b0;
    int_num_d  = int_num_q;
    vec_pend_d = vec_pend_q;
    st_d       = st_q;
    ea_d       = ea_q;
    prdata_d   = prdata_q;
    pready_d   = 1'b0;
    pslverr_d  = 1'b0;
    res        = 8'h00;
    corr       = 8'h00;
    upd_nz     = 1'b0;
    cin        = (OP_IN == CPRS_OP_ADC) ? flags_q[`CPRS_F_C] : 1'b0;
    sum9       = 9'h000;
    sum5       = 5'h00;

    // Effective address generation
    case (ADDR_MODE_IN)
      CPRS_AM_INDEX:       ea_d = index_q;
      CPRS_AM_INDEX_OFS:   ea_d = index_q + OFFSET_IN;
      CPRS_AM_STACK_OFS8:  ea_d = sp_q + {8'h00, OFFSET_IN[7:0]};
      CPRS_AM_STACK_OFS16: ea_d = sp_q + OFFSET_IN;
      default:             ea_d = index_q;
    endcase

    // Sequential fetch and jumps
    if (FETCH_IN) begin
      pc_d = pc_q + 16'h0001;
    end
    if (OP_IN == CPRS_OP_JUMP) begin
      pc_d = JUMP_ADDR_IN;
    end

    // Operation execution
    case (OP_IN)
      CPRS_OP_ADD, CPRS_OP_ADC: begin
        sum9 = {1'b0, acc_q} + {1'b0, OPERAND_IN} + {8'h00, cin};
        sum5 = {1'b0, acc_q[3:0]} + {1'b0, OPERAND_IN[3:0]} + {4'h0, cin};
        res  = sum9[7:0];
        acc_d = res;
        flags_d[`CPRS_F_H] = sum5[4];
        flags_d[`CPRS_F_C] = sum9[8];
        flags_d[`CPRS_F_V] = (acc_q[7] == OPERAND_IN[7]) & (res[7] != acc_q[7]);
        upd_nz = 1'b1;
      end
      CPRS_OP_SUB: begin
        sum9 = {1'b0, acc_q} - {1'b0, OPERAND_IN};
        res  = sum9[7:0];
        acc_d = res;
        flags_d[`CPRS_F_C] = sum9[8];
        flags_d[`CPRS_F_V] = (acc_q[7] != OPERAND_IN[7]) & (res[7] != acc_q[7]);
        upd_nz = 1'b1;
      end
      CPRS_OP_AND: begin
        res = acc_q & OPERAND_IN;
        acc_d = res;
        flags_d[`CPRS_F_V] = 1'b0;
        upd_nz = 1'b1;
      end
      CPRS_OP_LOAD_ACC: begin
        res = OPERAND_IN;
        acc_d = res;
        flags_d[`CPRS_F_V] = 1'b0;
        upd_nz = 1'b1;
      end
      CPRS_OP_ASL: begin
        res = {acc_q[6:0], 1'b0};
        acc_d = res;
        flags_d[`CPRS_F_C] = acc_q[7];
        flags_d[`CPRS_F_V] = acc_q[7] ^ acc_q[6];
        upd_nz = 1'b1;
      end
      CPRS_OP_LSR: begin
        res = {1'b0, acc_q[7:1]};
        acc_d = res;
        flags_d[`CPRS_F_C] = acc_q[0];
        flags_d[`CPRS_F_V] = acc_q[0];
        upd_nz = 1'b1;
      end
      CPRS_OP_DECIMAL_ADJUST: begin
        if (flags_q[`CPRS_F_H] || acc_q[3:0] > 4'h9) begin
          corr[3:0] = 4'h6;
        end
        if (flags_q[`CPRS_F_C] || acc_q > 8'h99) begin
          corr[7:4] = 4'h6;
        end
        sum9 = {1'b0, acc_q} + {1'b0, corr};
        res = sum9[7:0];
        acc_d = res;
        flags_d[`CPRS_F_C] = flags_q[`CPRS_F_C] | (corr[7:4] == 4'h6);
        upd_nz = 1'b1;
      end
      CPRS_OP_PUSH: sp_d = sp_q - 16'h0001;
      CPRS_OP_PULL: sp_d = sp_q + 16'h0001;
      CPRS_OP_RESET_STACK_LOW: sp_d = {sp_q[15:8], `CPRS_SP_LOW_ONE};
      CPRS_OP_MASK_CLEAR: flags_d[`CPRS_F_I] = 1'b0;
      CPRS_OP_MASK_SET: flags_d[`CPRS_F_I] = 1'b1;
      CPRS_OP_INTERRUPT_RETURN: begin
        // Pulled flags carry the stacked mask
        flags_d = PULL_DATA_IN[7:0];
        acc_d   = PULL_DATA_IN[15:8];
      end
      default: begin
      end
    endcase
    if (upd_nz) begin
      flags_d[`CPRS_F_N] = res[7];
      flags_d[`CPRS_F_Z] = (res == 8'h00);
    end

    // Interrupt sequencing: take a request, set the mask, then wait for the vector load
    case (st_q)
      CPRS_ST_RUN: begin
        if (|int_req_q && !flags_q[`CPRS_F_I] && OP_IN == CPRS_OP_NONE) begin
          int_num_d  = cprs_prio(int_req_q);
          int_take_d = 1'b1;
          st_d       = CPRS_ST_STACKED;
        end
      end
      CPRS_ST_STACKED: begin
        flags_d[`CPRS_F_I] = 1'b1;
        int_req_d[int_num_q] = 1'b0;
        st_d = CPRS_ST_VECTOR;
      end
      CPRS_ST_VECTOR: begin
        if (VECTOR_LOAD_IN) begin
          st_d = CPRS_ST_RUN;
        end
      end
      default: st_d = CPRS_ST_RUN;
    endcase

    // Vector load for reset and interrupts
    if (VECTOR_LOAD_IN) begin
      pc_d = VECTOR_IN;
      vec_pend_d = 1'b0;
    end

    // APB slave: single-wait answer, word-aligned registers
    if (apb_acc) begin
      pready_d = 1'b1;
      if (PWRITE_IN) begin
        case (idx)
          `CPRS_IDX_ACC:    if (PSTRB_IN[0]) acc_d = PWDATA_IN[7:0];
          `CPRS_IDX_INDEX: begin
            if (PSTRB_IN[0]) index_d[7:0]  = PWDATA_IN[7:0];
            if (PSTRB_IN[1]) index_d[15:8] = PWDATA_IN[15:8];
          end
          `CPRS_IDX_STACK: begin
            if (PSTRB_IN[0]) sp_d[7:0]  = PWDATA_IN[7:0];
            if (PSTRB_IN[1]) sp_d[15:8] = PWDATA_IN[15:8];
          end
          `CPRS_IDX_PROG: begin
            if (PSTRB_IN[0]) pc_d[7:0]  = PWDATA_IN[7:0];
            if (PSTRB_IN[1]) pc_d[15:8] = PWDATA_IN[15:8];
          end
          `CPRS_IDX_FLAGS:  if (PSTRB_IN[0]) flags_d = PWDATA_IN[7:0];
          `CPRS_IDX_INTREQ: if (PSTRB_IN[0]) int_req_d = int_req_d | PWDATA_IN[7:0];
          `CPRS_IDX_INTCTL: if (PSTRB_IN[0]) int_req_d = int_req_d & ~PWDATA_IN[7:0];
          default: pslverr_d = 1'b1;
        endcase
      end else begin
        case (idx)
          `CPRS_IDX_ACC:    prdata_d = {24'h000000, acc_q};
          `CPRS_IDX_INDEX:  prdata_d = {16'h0000, index_q};
          `CPRS_IDX_STACK:  prdata_d = {16'h0000, sp_q};
          `CPRS_IDX_PROG:   prdata_d = {16'h0000, pc_q};
          `CPRS_IDX_FLAGS:  prdata_d = {24'h000000, cprs_fix(flags_q)};
          `CPRS_IDX_INTREQ: prdata_d = {24'h000000, int_req_q};
          `CPRS_IDX_INTCTL: prdata_d = {21'h000000, int_num_q, 6'h00, st_q};
          default: begin
            prdata_d  = 32'h00000000;
            pslverr_d = 1'b1;
          end
        endcase
      end
      if (PADDR_IN[11:6] != 6'h00 || PADDR_IN[1:0] != 2'h0) begin
        pslverr_d = 1'b1;
      end
    end
    flags_d = cprs_fix(flags_d);
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      acc_q      <= 8'h00;
      index_q    <= 16'h0000;
      sp_q       <= `CPRS_SP_RST;
      pc_q       <= 16'h0000;
      flags_q    <= `CPRS_FLAGS_RST;
      int_req_q  <= 8'h00;
      int_take_q <= 1'b0;
      int_num_q  <= 3'd0;
      vec_pend_q <= 1'b1;
      st_q       <= CPRS_ST_RUN;
      ea_q       <= 16'h0000;
      prdata_q   <= 32'h00000000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else if (CLK_EN_IN) begin
      acc_q      <= acc_d;
      index_q    <= index_d;
      sp_q       <= sp_d;
      pc_q       <= pc_d;
      flags_q    <= flags_d;
      int_req_q  <= int_req_d;
      int_take_q <= int_take_d;
      int_num_q  <= int_num_d;
      vec_pend_q <= vec_pend_d;
      st_q       <= st_d;
      ea_q       <= ea_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  // Outputs straight from flip-flops
  assign PRDATA_OUT        = prdata_q;
  assign PREADY_OUT        = pready_q;
  assign PSLVERR_OUT       = pslverr_q;
  assign EFF_ADDR_OUT      = ea_q;
  assign PROG_ADDR_OUT     = pc_q;
  assign STACK_ADDR_OUT    = sp_q;
  assign ACC_OUT           = acc_q;
  assign FLAGS_OUT         = flags_q;
  assign INT_TAKE_OUT      = int_take_q;
  assign INT_NUM_OUT       = int_num_q;
  assign RESET_VEC_REQ_OUT = vec_pend_q;

endmodule

// File: cprs_regs.svh
`ifndef CPRS_REGS_SVH
`define CPRS_REGS_SVH
// Register indexes (byte address = index * 4)
`define CPRS_IDX_ACC    4'h0
`define CPRS_IDX_INDEX  4'h1
`define CPRS_IDX_STACK  4'h2
`define CPRS_IDX_PROG   4'h3
`define CPRS_IDX_FLAGS  4'h4
`define CPRS_IDX_INTREQ 4'h5
`define CPRS_IDX_INTCTL 4'h6
// Reset values
`define CPRS_SP_RST     16'h00FF
`define CPRS_FLAGS_RST  8'h68
`define CPRS_SP_LOW_ONE 8'hFF
// Flag bit positions
`define CPRS_F_V        3'd7
`define CPRS_F_ONE6     3'd6
`define CPRS_F_ONE5     3'd5
`define CPRS_F_H        3'd4
`define CPRS_F_I        3'd3
`define CPRS_F_N        3'd2
`define CPRS_F_Z        3'd1
`define CPRS_F_C        3'd0
`define CPRS_FLAGS_FIX  8'h60
`endif

// File: cprs_pkg.sv
package cprs_pkg;
  // Execution-unit operations applied to the register set
  typedef enum logic [3:0] {
    CPRS_OP_NONE, CPRS_OP_ADD, CPRS_OP_ADC, CPRS_OP_SUB, CPRS_OP_AND,
    CPRS_OP_ASL, CPRS_OP_LSR, CPRS_OP_DECIMAL_ADJUST, CPRS_OP_PUSH, CPRS_OP_PULL,
    CPRS_OP_RESET_STACK_LOW, CPRS_OP_MASK_CLEAR, CPRS_OP_MASK_SET,
    CPRS_OP_INTERRUPT_RETURN, CPRS_OP_JUMP, CPRS_OP_LOAD_ACC
  } cprs_op_e;
  typedef enum logic [1:0] {
    CPRS_AM_INDEX, CPRS_AM_INDEX_OFS, CPRS_AM_STACK_OFS8, CPRS_AM_STACK_OFS16
  } cprs_am_e;
endpackage

// File: cprs_core_asserts.sv
`timescale 1ns/1ps
module cprs_core_asserts
  import cprs_pkg::*;
(
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        CLK_EN_IN,
  input wire logic        PSEL_IN,
  input wire cprs_op_e    OP_IN,
  input wire logic        VECTOR_LOAD_IN,
  input wire logic [15:0] VECTOR_IN,
  input wire logic [15:0] PROG_ADDR_OUT,
  input wire logic [15:0] STACK_ADDR_OUT,
  input wire logic [7:0]  ACC_OUT,
  input wire logic [7:0]  FLAGS_OUT,
  input wire logic        INT_TAKE_OUT
);
  // Core clock sampling, quiet in reset
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Enabled cycle with no bus access competing for a register
  logic go;
  assign go = CLK_EN_IN && !PSEL_IN;
  property p_fix; FLAGS_OUT[6:5] == 2'h3; endproperty
  a_fix: assert property (p_fix) else $error("fixed flag bits low");
  property p_push; go && OP_IN == CPRS_OP_PUSH |=>
    STACK_ADDR_OUT == $past(STACK_ADDR_OUT) - 16'h0001; endproperty
  a_push: assert property (p_push) else $error("push step wrong");
  property p_pull; go && OP_IN == CPRS_OP_PULL |=>
    STACK_ADDR_OUT == $past(STACK_ADDR_OUT) + 16'h0001; endproperty
  a_pull: assert property (p_pull) else $error("pull step wrong");
  property p_rsp; go && OP_IN == CPRS_OP_RESET_STACK_LOW |=> STACK_ADDR_OUT[7:0] == 8'hFF
    && ((STACK_ADDR_OUT ^ $past(STACK_ADDR_OUT)) & 16'hFF00) == 16'h0000; endproperty
  a_rsp: assert property (p_rsp) else $error("stack low reset wrong");
  property p_vec; go && VECTOR_LOAD_IN |=> PROG_ADDR_OUT == $past(VECTOR_IN); endproperty
  a_vec: assert property (p_vec) else $error("vector not loaded");
  property p_take; CLK_EN_IN && INT_TAKE_OUT |=> FLAGS_OUT[3]; endproperty
  a_take: assert property (p_take) else $error("mask not set on entry");
  property p_block; FLAGS_OUT[3] |=> !INT_TAKE_OUT; endproperty
  a_block: assert property (p_block) else $error("masked entry taken");
  property p_add; go && OP_IN == CPRS_OP_ADD |=>
    FLAGS_OUT[2] == ACC_OUT[7] && FLAGS_OUT[1] == (ACC_OUT == 8'h00); endproperty
  a_add: assert property (p_add) else $error("sign or zero flag wrong");
  // Main scenarios reached
  c_push: cover property (go && OP_IN == CPRS_OP_PUSH);
  c_take: cover property (INT_TAKE_OUT);
  c_vec: cover property (go && VECTOR_LOAD_IN);
endmodule
bind cprs_core cprs_core_asserts i_cprs_core_asserts (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN), .CLK_EN_IN(CLK_EN_IN), .PSEL_IN(PSEL_IN),
  .OP_IN(OP_IN), .VECTOR_LOAD_IN(VECTOR_LOAD_IN), .VECTOR_IN(VECTOR_IN),
  .PROG_ADDR_OUT(PROG_ADDR_OUT), .STACK_ADDR_OUT(STACK_ADDR_OUT), .ACC_OUT(ACC_OUT),
  .FLAGS_OUT(FLAGS_OUT), .INT_TAKE_OUT(INT_TAKE_OUT));

// File: cprs_core_tb.sv
`timescale 1ns/1ps
module cprs_core_tb
  import cprs_pkg::*;
;
  logic        clk, rst_b, psel, penable, pwrite, fetch, vload, pready, err, take, vreq;
  logic        en, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  cprs_op_e    op;
  cprs_am_e    am;
  logic [7:0]  opnd, acc, flags, m_acc, m_fl;
  logic [15:0] xa, offs, eff, pc, sp, m_sp, m_pc;
  logic [2:0]  inum;
  int          fails, comparisons, cyc;
  cprs_op_e    alus[8] = '{CPRS_OP_ADD, CPRS_OP_ADC, CPRS_OP_SUB, CPRS_OP_AND,
    CPRS_OP_LOAD_ACC, CPRS_OP_ASL, CPRS_OP_LSR, CPRS_OP_DECIMAL_ADJUST};
  cprs_core i_cprs_core (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(en),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PSTRB_IN(4'hF), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(err), .OP_IN(op), .OPERAND_IN(opnd), .PULL_DATA_IN(xa), .FETCH_IN(fetch),
    .JUMP_ADDR_IN(xa), .VECTOR_LOAD_IN(vload), .VECTOR_IN(xa), .ADDR_MODE_IN(am),
    .OFFSET_IN(offs), .EFF_ADDR_OUT(eff), .PROG_ADDR_OUT(pc), .STACK_ADDR_OUT(sp),
    .ACC_OUT(acc), .FLAGS_OUT(flags), .INT_TAKE_OUT(take), .INT_NUM_OUT(inum),
    .RESET_VEC_REQ_OUT(vreq));
  // Clock and cycle ceiling
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Bus transfer: setup, access, hold until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    // Ready, data and error are taken at the rising edge that ends the access
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    chk(pready, 1'h1);
    rd = prdata;
    rerr = err;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmp();
    chk(acc, m_acc);
    chk(flags, m_fl);
    chk(pc, m_pc);
    chk(sp, m_sp);
  endtask
  // One execution cycle, then the model steps and is compared
  task automatic ex(cprs_op_e o, logic [7:0] v, logic f, logic vl, logic [15:0] a);
    logic [8:0] r;
    logic       c;
    logic       cy;
    @(posedge clk);
    op <= o;
    opnd <= v;
    fetch <= f;
    vload <= vl;
    xa <= a;
    @(posedge clk);
    op <= CPRS_OP_NONE;
    fetch <= 1'h0;
    vload <= 1'h0;
    c = (o == CPRS_OP_ADC) ? m_fl[0] : 1'h0;
    cy = m_fl[0];
    r = {1'h0, m_acc & v};
    case (o)
      CPRS_OP_ADD, CPRS_OP_ADC: begin
        r = m_acc + v + c;
        cy = r[8];
        m_fl[4] = (m_acc[3:0] + v[3:0] + c) > 15;
        m_fl[7] = (m_acc[7] == v[7]) && (r[7] != m_acc[7]);
      end
      CPRS_OP_SUB: begin
        r = m_acc - v;
        cy = r[8];
        m_fl[7] = (m_acc[7] != v[7]) && (r[7] != m_acc[7]);
      end
      CPRS_OP_AND: m_fl[7] = 1'h0;
      CPRS_OP_LOAD_ACC: begin
        r = {1'h0, v};
        m_fl[7] = 1'h0;
      end
      // Shifts: overflow is sign xor carry of the result
      CPRS_OP_ASL: begin
        r = {m_acc, 1'h0};
        cy = m_acc[7];
        m_fl[7] = m_acc[7] ^ m_acc[6];
      end
      CPRS_OP_LSR: begin
        r = {2'h0, m_acc[7:1]};
        cy = m_acc[0];
        m_fl[7] = m_acc[0];
      end
      // BCD correction chosen from half-carry, carry and the digits
      CPRS_OP_DECIMAL_ADJUST: begin
        cy = m_fl[0] || m_acc > 8'h99;
        r = m_acc + ((m_fl[4] || m_acc[3:0] > 4'h9) ? 8'h06 : 8'h00) + (cy ? 8'h60 : 8'h00);
      end
      CPRS_OP_MASK_SET: m_fl[3] = 1'h1;
      CPRS_OP_PUSH: m_sp--;
      CPRS_OP_PULL: m_sp++;
      CPRS_OP_RESET_STACK_LOW: m_sp[7:0] = 8'hFF;
      CPRS_OP_MASK_CLEAR: m_fl[3] = 1'h0;
      CPRS_OP_INTERRUPT_RETURN: {m_acc, m_fl} = a | 16'h0060;
      CPRS_OP_JUMP: m_pc = a - 16'(f);
      default: ;
    endcase
    if (o inside {CPRS_OP_ADD, CPRS_OP_ADC, CPRS_OP_SUB, CPRS_OP_AND, CPRS_OP_LOAD_ACC,
                  CPRS_OP_ASL, CPRS_OP_LSR, CPRS_OP_DECIMAL_ADJUST}) begin
      m_acc = r[7:0];
      m_fl[2:0] = {r[7], r[7:0] == 8'h00, cy};
    end
    m_pc = vl ? a : m_pc + 16'(f);
    @(negedge clk);
    cmp();
  endtask
  // Wait for interrupt entry and check source and mask
  task automatic wt(input logic [2:0] num);
    int n;
    n = 0;
    while (take !== 1'h1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(inum, num);
    @(negedge clk);
    chk(flags[3], 1'h1);
    m_fl[3] = 1'h1;
  endtask
  // Main sequence
  initial begin
    {clk, rst_b, psel, penable, pwrite, fetch, vload, paddr, pwdata, opnd, xa} = '0;
    op = CPRS_OP_NONE;
    en = 1'h1;
    am = CPRS_AM_INDEX;
    offs = 16'h0010;
    seed = 32'h234CEDCF;
    {m_acc, m_fl, m_sp, m_pc} = {8'h00, 8'h68, 16'h00FF, 16'h0000};
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    @(negedge clk);
    cmp();
    chk(vreq, 1'h1);
    apb(1'h0, 12'h010, 32'h0);
    chk(rd, 32'h68);
    chk(rerr, 1'h0);
    ex(CPRS_OP_NONE, 8'h00, 1'h0, 1'h1, 16'hC3A0);
    chk(vreq, 1'h0);
    repeat (3) ex(CPRS_OP_NONE, 8'h00, 1'h1, 1'h0, 16'h0000);
    ex(CPRS_OP_JUMP, 8'h00, 1'h1, 1'h0, 16'hFFFF);
    ex(CPRS_OP_NONE, 8'h00, 1'h1, 1'h0, 16'h0000);
    apb(1'h1, 12'h008, 32'h1200);
    m_sp = 16'h1200;
    ex(CPRS_OP_PUSH, 8'h00, 1'h0, 1'h0, 16'h0000);
    ex(CPRS_OP_PULL, 8'h00, 1'h0, 1'h0, 16'h0000);
    ex(CPRS_OP_RESET_STACK_LOW, 8'h00, 1'h0, 1'h0, 16'h0000);
    apb(1'h1, 12'h004, 32'h8421);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h8421);
    chk(eff, 16'h8421);
    am <= CPRS_AM_STACK_OFS16;
    repeat (2) @(negedge clk);
    chk(eff, m_sp + 16'h0010);
    // Eight-bit stack offset takes only the low offset byte
    @(posedge clk);
    am <= CPRS_AM_STACK_OFS8;
    offs <= 16'hFF80;
    repeat (2) @(negedge clk);
    chk(eff, m_sp + 16'h0080);
    @(posedge clk);
    am <= CPRS_AM_INDEX_OFS;
    repeat (2) @(negedge clk);
    chk(eff, 16'(16'h8421 + 16'hFF80));
    repeat (40) begin
      seed = lfsr(seed);
      ex(alus[seed[2:0]], seed[15:8], seed[16], 1'h0, 16'h0000);
    end
    apb(1'h1, 12'h010, 32'h0F);
    m_fl = 8'h6F;
    apb(1'h0, 12'h010, 32'h0);
    chk(rd, 32'h6F);
    apb(1'h0, 12'h01C, 32'h0);
    chk(rerr, 1'h1);
    apb(1'h1, 12'h014, 32'h6);
    repeat (4) @(negedge clk);
    chk(take, 1'h0);
    ex(CPRS_OP_MASK_CLEAR, 8'h00, 1'h0, 1'h0, 16'h0000);
    wt(3'h1);
    ex(CPRS_OP_NONE, 8'h00, 1'h0, 1'h1, 16'h4000);
    ex(CPRS_OP_MASK_CLEAR, 8'h00, 1'h0, 1'h0, 16'h0000);
    wt(3'h2);
    ex(CPRS_OP_NONE, 8'h00, 1'h0, 1'h1, 16'h4100);
    ex(CPRS_OP_INTERRUPT_RETURN, 8'h00, 1'h0, 1'h0, 16'hA5C0);
    ex(CPRS_OP_MASK_SET, 8'h00, 1'h0, 1'h0, 16'h0000);
    // A push held while the clock enable is low must not move the stack
    @(posedge clk);
    en <= 1'h0;
    op <= CPRS_OP_PUSH;
    repeat (2) @(posedge clk);
    en <= 1'h1;
    op <= CPRS_OP_NONE;
    @(negedge clk);
    cmp();
    results();
  end
endmodule
